// ==== hdl/lpm_defines.svh ====
// register offsets, field positions and reset values of the power-mode controller
`ifndef LPM_DEFINES_SVH
`define LPM_DEFINES_SVH
`define LPM_CTRL_OFF 8'h00
`define LPM_SUPPLY_OFF 8'h04
`define LPM_STAT_OFF 8'h08
`define LPM_CTRL_VOS_BIT 9
`define LPM_CTRL_LPR_BIT 14
`define LPM_CTRL_CSSEN_BIT 15
`define LPM_SUP_EN_BIT 0
`define LPM_SUP_SRC_BIT 4
`define LPM_SUP_LVL_LO 5
`define LPM_SUP_LVL_HI 7
`define LPM_CTRL_RESET 32'h00000000
`define LPM_SUPPLY_RESET 32'h00000000
`endif

// ==== hdl/lpm_pkg.sv ====
// types of the power-mode controller
package lpm_pkg;
  typedef enum logic [4:0] {
    st_run = 5'h01,
    st_sleep_wfi = 5'h02,
    st_sleep_wfe = 5'h04,
    st_stop_wfi = 5'h08,
    st_stop_wfe = 5'h10
  } mode_type;
endpackage

// ==== hdl/low_power_mode_control.sv ====
// power-mode controller: regulator choice, sleep and stop sequencing, clock gating
// Functional notes
// - run: main regulator at 1.2 V, other off
// - stop supply chosen by regulator select bit
// - low-power regulator 1.2 V, 1.0 V with select
// - stop exit: main regulator, clear voltage select
// - reduced range only in stop on low-power regulator
// - power-down reset active in every mode
// - brown-out settings only from option bytes
// - threshold detector compares supply or pin level
// - detector output drives event line 16
// - sleep stops only processor clock
// - sleep-now on wait instruction
// - sleep-after-handler on handler return, interrupt wake
// - interrupt-entered sleep wakes on accepted interrupt
// - event-entered sleep wakes on event
// - pins keep run-mode state in sleep
// - deep-sleep select plus wait enters stop
// - stop turns off fast oscillators and pll
// - stop wakes on line, watchdog, reset pin
// - slow oscillator failure in stop raises nmi
// - stop leaves only low-power peripherals clocked
// - regulator select bit 14, 1 = low-power
// - voltage select bit 9, 1 = 1.0 V
// - pending flags at stop request ignore it
//
// Our own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "lpm_defines.svh"
module low_power_mode_control (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clock_enable,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // processor core
  input wire logic wfi_exec,
  input wire logic wfe_exec,
  input wire logic handler_return,
  input wire logic deep_sleep_select,
  input wire logic sleep_after_handler,
  input wire logic pending_as_event,
  input wire logic core_sleeping,
  // interrupt controller and event lines
  input wire logic irq_accepted,
  input wire logic periph_pending,
  input wire logic line_pending,
  input wire logic alarm_pending,
  input wire logic line_event,
  input wire logic line_wake_irq,
  input wire logic watchdog_wake,
  input wire logic reset_pin_wake,
  input wire logic slow_osc_fail,
  input wire logic sysclk_is_slow,
  // option bytes and analog
  input wire logic opt_brownout_en,
  input wire logic [2:0] opt_brownout_rise,
  input wire logic [2:0] opt_brownout_fall,
  input wire logic supply_above_raw,
  // outputs
  output logic cpu_clock_en,
  output logic main_regulator_on,
  output logic low_power_regulator_on,
  output logic core_volt_low,
  output logic fast_osc_off,
  output logic periph_clock_en,
  output logic sleep_active,
  output logic stop_active,
  output logic power_down_reset_en,
  output logic brownout_reset_en,
  output logic [2:0] brownout_rise_sel,
  output logic [2:0] brownout_fall_sel,
  output logic detector_enable,
  output logic detector_src_pin,
  output logic [2:0] detector_level,
  output logic event_line16,
  output logic nmi_request
);
  // ***********************************
  // register bus
  // ***********************************
  logic [31:0] ctrl_q;
  logic [31:0] supply_q;
  logic [7:0] addr_q;
  logic wr_q;
  logic stop_exit;
  logic [1:0] sup_sync_q;
  logic cssen_latched_q;
  lpm_pkg::mode_type mode_q;
  lpm_pkg::mode_type mode_d;

  wire access = hsel && hready && htrans[1];
  wire ctrl_wr = wr_q && (addr_q == `LPM_CTRL_OFF);
  wire supply_wr = wr_q && (addr_q == `LPM_SUPPLY_OFF);

  // register read decode; unmapped offsets read as zero
  function automatic logic [31:0] reg_read(input logic [7:0] offset,
                                           input logic [31:0] ctrl_word,
                                           input logic [31:0] supply_word,
                                           input logic [31:0] status_word);
    logic [31:0] word;
    word = 32'h00000000;
    case (offset)
      `LPM_CTRL_OFF: word = ctrl_word;
      `LPM_SUPPLY_OFF: word = supply_word;
      `LPM_STAT_OFF: word = status_word;
      default: word = 32'h00000000;
    endcase
    return word;
  endfunction

  // status view: synced supply flag, latched monitor enable, one-hot mode
  wire [31:0] stat_word = {22'h000000, sup_sync_q[1], cssen_latched_q, 3'h0, mode_q};

  // next register contents; the hardware clear of the voltage select
  // wins over a software write that lands in the same cycle
  wire [31:0] vos_mask = 32'h00000001 << `LPM_CTRL_VOS_BIT;
  wire [31:0] ctrl_written = ctrl_wr ? hwdata : ctrl_q;
  wire [31:0] ctrl_d = stop_exit ? (ctrl_written & ~vos_mask) : ctrl_written;
  wire [31:0] supply_d = supply_wr ? hwdata : supply_q;

  // read data comes from the next contents, so a read issued right
  // behind a write to the same register already returns the new word
  wire [31:0] rd_word = reg_read(haddr[7:0], ctrl_d, supply_d, stat_word);

  // address phase capture; zero-wait answer
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      addr_q <= 8'h00;
      wr_q <= 1'b0;
    end else if (clock_enable) begin
      addr_q <= haddr[7:0];
      wr_q <= access && hwrite;
    end
  end

  // read data register
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (clock_enable) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (access && !hwrite) begin
        hrdata <= rd_word;
      end
    end
  end

  // control register; voltage select cleared by hardware at stop exit
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= `LPM_CTRL_RESET;
    end else if (clock_enable) begin
      ctrl_q <= ctrl_d;
    end
  end

  // detector configuration register
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      supply_q <= `LPM_SUPPLY_RESET;
    end else if (clock_enable) begin
      supply_q <= supply_d;
    end
  end

  // ***********************************
  // mode sequencer
  // ***********************************
  wire reg_select_lp = ctrl_q[`LPM_CTRL_LPR_BIT];
  wire volt_select_low = ctrl_q[`LPM_CTRL_VOS_BIT];
  // any of these flags makes a stop request fall through to run
  wire any_pending = line_pending || periph_pending || alarm_pending;
  // sleep-now or sleep-after-handler entry
  wire sleep_wfi_go = !deep_sleep_select && core_sleeping &&
                      ((!sleep_after_handler && wfi_exec) ||
                       (sleep_after_handler && handler_return));
  wire sleep_wfe_go = !deep_sleep_select && !sleep_after_handler &&
                      core_sleeping && wfe_exec;
  // stop entry, refused on pending flags or slow system clock
  wire stop_ok = deep_sleep_select && core_sleeping && !any_pending &&
                 !sysclk_is_slow;
  wire stop_wfi_go = stop_ok && (wfi_exec || handler_return);
  // both wait flags together count as wfi: the case below tries it first
  wire stop_wfe_go = stop_ok && wfe_exec;
  wire event_wake = line_event || (pending_as_event && periph_pending);
  wire stop_common = watchdog_wake || reset_pin_wake ||
                     (cssen_latched_q && slow_osc_fail);

  // next mode
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      lpm_pkg::st_run: begin
        if (stop_wfi_go) begin
          mode_d = lpm_pkg::st_stop_wfi;
        end else if (stop_wfe_go) begin
          mode_d = lpm_pkg::st_stop_wfe;
        end else if (sleep_wfi_go) begin
          mode_d = lpm_pkg::st_sleep_wfi;
        end else if (sleep_wfe_go) begin
          mode_d = lpm_pkg::st_sleep_wfe;
        end
      end
      lpm_pkg::st_sleep_wfi: begin
        if (irq_accepted) begin
          mode_d = lpm_pkg::st_run;
        end
      end
      lpm_pkg::st_sleep_wfe: begin
        if (event_wake) begin
          mode_d = lpm_pkg::st_run;
        end
      end
      lpm_pkg::st_stop_wfi: begin
        if (line_wake_irq || stop_common) begin
          mode_d = lpm_pkg::st_run;
        end
      end
      lpm_pkg::st_stop_wfe: begin
        if (event_wake || stop_common) begin
          mode_d = lpm_pkg::st_run;
        end
      end
      default: begin
        mode_d = lpm_pkg::st_run;
      end
    endcase
  end

  // stop state test, used on the present and on the next mode
  function automatic logic is_stop(input lpm_pkg::mode_type mode);
    return (mode == lpm_pkg::st_stop_wfi) || (mode == lpm_pkg::st_stop_wfe);
  endfunction

  // sleep state test; either entry path counts
  function automatic logic is_sleep(input lpm_pkg::mode_type mode);
    return (mode == lpm_pkg::st_sleep_wfi) || (mode == lpm_pkg::st_sleep_wfe);
  endfunction

  // present and next mode classes
  wire in_stop = is_stop(mode_q);
  wire next_stop = is_stop(mode_d);
  wire next_sleep = is_sleep(mode_d);
  wire next_run = (mode_d == lpm_pkg::st_run);
  assign stop_exit = in_stop && next_run;
  wire entering_stop = (mode_q == lpm_pkg::st_run) && next_stop;

  // mode register and monitor enable caught at stop entry
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mode_q <= lpm_pkg::st_run;
      cssen_latched_q <= 1'b0;
    end else if (clock_enable) begin
      mode_q <= mode_d;
      if (entering_stop) begin
        cssen_latched_q <= ctrl_q[`LPM_CTRL_CSSEN_BIT];
      end else if (next_run) begin
        cssen_latched_q <= 1'b0;
      end
    end
  end

  // supply detector input synchroniser
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sup_sync_q <= 2'b00;
    end else if (clock_enable) begin
      sup_sync_q <= {sup_sync_q[0], supply_above_raw};
    end
  end

  // ***********************************
  // registered outputs
  // ***********************************
  // every mode output except nmi_request is computed from the next mode, so it changes on the
  // same edge as the mode register and never lags the state by a cycle
  wire lp_stop = next_stop && reg_select_lp;

  // processor clock gate; off in both low-power modes
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cpu_clock_en <= 1'b1;
    end else if (clock_enable) begin
      cpu_clock_en <= next_run;
    end
  end

  // regulator choice and core voltage; the low voltage is only
  // allowed while the low-power regulator feeds the core in stop
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      main_regulator_on <= 1'b1;
      low_power_regulator_on <= 1'b0;
      core_volt_low <= 1'b0;
    end else if (clock_enable) begin
      main_regulator_on <= !lp_stop;
      low_power_regulator_on <= lp_stop;
      core_volt_low <= lp_stop && volt_select_low;
    end
  end

  // oscillator and peripheral clock gating; sleep leaves both running
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      fast_osc_off <= 1'b0;
      periph_clock_en <= 1'b1;
    end else if (clock_enable) begin
      fast_osc_off <= next_stop;
      periph_clock_en <= !next_stop;
    end
  end

  // mode flags seen by the rest of the chip
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sleep_active <= 1'b0;
      stop_active <= 1'b0;
    end else if (clock_enable) begin
      sleep_active <= next_sleep;
      stop_active <= next_stop;
    end
  end

  // reset monitors; brown-out settings follow the option inputs only,
  // no register can reach them
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      power_down_reset_en <= 1'b1;
      brownout_reset_en <= 1'b0;
      brownout_rise_sel <= 3'h0;
      brownout_fall_sel <= 3'h0;
    end else if (clock_enable) begin
      power_down_reset_en <= 1'b1;
      brownout_reset_en <= opt_brownout_en;
      brownout_rise_sel <= opt_brownout_rise;
      brownout_fall_sel <= opt_brownout_fall;
    end
  end

  // threshold detector configuration and its event line
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      detector_enable <= 1'b0;
      detector_src_pin <= 1'b0;
      detector_level <= 3'h0;
      event_line16 <= 1'b0;
    end else if (clock_enable) begin
      detector_enable <= supply_q[`LPM_SUP_EN_BIT];
      detector_src_pin <= supply_q[`LPM_SUP_SRC_BIT];
      detector_level <= supply_q[`LPM_SUP_LVL_HI:`LPM_SUP_LVL_LO];
      event_line16 <= supply_q[`LPM_SUP_EN_BIT] && sup_sync_q[1];
    end
  end

  // non-maskable request on a slow oscillator failure during stop;
  // a single pulse, since the same failure also ends stop
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      nmi_request <= 1'b0;
    end else if (clock_enable) begin
      nmi_request <= in_stop && cssen_latched_q && slow_osc_fail;
    end
  end
endmodule
`default_nettype wire

// ==== bench/core_model.sv ====
// behavioural model of the processor core side
`timescale 1ns/100ps
`default_nettype none
module core_model (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic cpu_clock_en,
  input wire logic [1:0] req,
  output logic wfi_exec,
  output logic wfe_exec,
  output logic handler_return,
  output logic core_sleeping
);
  // *****************
  // wait instructions
  // *****************
  // one-cycle instruction pulse, sleeping held until clock returns
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      {wfi_exec, wfe_exec, handler_return, core_sleeping} <= 4'h0;
    end else begin
      wfi_exec <= (req == 2'h1);
      wfe_exec <= (req == 2'h2);
      handler_return <= (req == 2'h3);
      core_sleeping <= (req != 2'h0) |
        (core_sleeping & (wfi_exec | wfe_exec | handler_return | !cpu_clock_en));
    end
  end
endmodule
`default_nettype wire

// ==== bench/lpm_checker_assertions.sv ====
// port assertions of the power-mode controller
`timescale 1ns/100ps
`default_nettype none
module lpm_checker (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clock_enable,
  input wire logic wfi_exec,
  input wire logic wfe_exec,
  input wire logic deep_sleep_select,
  input wire logic sleep_after_handler,
  input wire logic core_sleeping,
  input wire logic line_pending,
  input wire logic periph_pending,
  input wire logic alarm_pending,
  input wire logic sysclk_is_slow,
  input wire logic watchdog_wake,
  input wire logic reset_pin_wake,
  input wire logic opt_brownout_en,
  input wire logic [2:0] opt_brownout_rise,
  input wire logic supply_above_raw,
  input wire logic cpu_clock_en,
  input wire logic main_regulator_on,
  input wire logic low_power_regulator_on,
  input wire logic core_volt_low,
  input wire logic fast_osc_off,
  input wire logic periph_clock_en,
  input wire logic sleep_active,
  input wire logic stop_active,
  input wire logic power_down_reset_en,
  input wire logic brownout_reset_en,
  input wire logic [2:0] brownout_rise_sel,
  input wire logic detector_enable,
  input wire logic event_line16
);
  // ********
  // sequences
  // ********
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  wire run = !sleep_active && !stop_active;
  wire pend = line_pending | periph_pending | alarm_pending | sysclk_is_slow;
  wire taken = clock_enable && run && core_sleeping && (wfi_exec || wfe_exec);
  sequence s_stop_ok;
    taken && deep_sleep_select && !pend;
  endsequence
  sequence s_stop_bad;
    taken && deep_sleep_select && pend;
  endsequence
  sequence s_above;
    (detector_enable && supply_above_raw) [*5];
  endsequence
  // ********
  // properties
  // ********
  property p_run_supply;
    run |-> main_regulator_on && !low_power_regulator_on && !core_volt_low;
  endproperty
  a_run_supply: assert property (p_run_supply)
    else $error("run supply wrong");
  property p_low_volt;
    core_volt_low |-> stop_active && low_power_regulator_on;
  endproperty
  a_low_volt: assert property (p_low_volt)
    else $error("low voltage outside stop");
  property p_pdr;
    power_down_reset_en;
  endproperty
  a_pdr: assert property (p_pdr)
    else $error("power-down reset off");
  property p_bor;
    reset_n && clock_enable |=> brownout_reset_en == $past(opt_brownout_en)
      && brownout_rise_sel == $past(opt_brownout_rise);
  endproperty
  a_bor: assert property (p_bor)
    else $error("brown-out setting not from option");
  property p_sleep_now;
    taken && !deep_sleep_select && !sleep_after_handler |=> sleep_active && !cpu_clock_en;
  endproperty
  a_sleep_now: assert property (p_sleep_now)
    else $error("sleep not entered");
  property p_sleep_clk;
    sleep_active |-> main_regulator_on && !fast_osc_off && periph_clock_en;
  endproperty
  a_sleep_clk: assert property (p_sleep_clk)
    else $error("sleep touched other clocks");
  property p_stop_entry;
    s_stop_ok |=> stop_active && !cpu_clock_en && fast_osc_off && !periph_clock_en;
  endproperty
  a_stop_entry: assert property (p_stop_entry)
    else $error("stop not entered");
  property p_stop_refuse;
    s_stop_bad |=> !stop_active && cpu_clock_en;
  endproperty
  a_stop_refuse: assert property (p_stop_refuse)
    else $error("stop entered while pending");
  property p_stop_wake;
    stop_active && clock_enable && (watchdog_wake || reset_pin_wake)
      |=> cpu_clock_en && main_regulator_on && !core_volt_low && !fast_osc_off;
  endproperty
  a_stop_wake: assert property (p_stop_wake)
    else $error("stop wake wrong");
  property p_event;
    s_above |-> event_line16;
  endproperty
  a_event: assert property (p_event)
    else $error("event line not raised");
endmodule
bind low_power_mode_control lpm_checker u_chk (.*);
`default_nettype wire

// ==== bench/test_low_power_mode_control.sv ====
// self-checking bench of the power-mode controller
`timescale 1ns/100ps
`default_nettype none
`include "lpm_defines.svh"
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin failures++; \
  $display("unexpected %s exp %h got %h", n, e, s); end end
module test_low_power_mode_control;
  logic clock, reset_n, clock_enable, hsel, hwrite, hreadyout, hresp, supply_above_raw;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, req;
  logic [3:0] wk;
  logic [2:0] hsize, opt_brownout_rise, opt_brownout_fall, brownout_rise_sel;
  logic [2:0] brownout_fall_sel, detector_level;
  logic wfi_exec, wfe_exec, handler_return, deep_sleep_select, sleep_after_handler;
  logic pending_as_event, core_sleeping, periph_pending, line_pending, alarm_pending;
  logic line_wake_irq, slow_osc_fail, sysclk_is_slow, opt_brownout_en, cpu_clock_en;
  logic main_regulator_on, low_power_regulator_on, core_volt_low, fast_osc_off;
  logic periph_clock_en, sleep_active, stop_active, power_down_reset_en;
  logic brownout_reset_en, detector_enable, detector_src_pin, event_line16, nmi_request;
  wire irq_accepted = wk[0];
  wire line_event = wk[1];
  wire watchdog_wake = wk[2];
  wire reset_pin_wake = wk[3];
  int failures, num_checks, cycles;
  low_power_mode_control u_dut (.hready(hreadyout), .*);
  core_model u_core (.*);
  // clock and hang guard
  always #4 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      end_of_test;
    end
  end
  // ********
  // tasks
  // ********
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic go(input logic [1:0] k);
    req <= k;
    @(posedge clock) req <= 2'b00;
    repeat (3) @(posedge clock);
  endtask
  task automatic wake(input int i);
    wk <= 4'h1 << i;
    @(posedge clock) wk <= 4'h0;
    repeat (2) @(posedge clock);
  endtask
  task automatic t_regs;
    bus(0, `LPM_CTRL_OFF, 0); `CHK("ctrl", `LPM_CTRL_RESET, rd)
    bus(0, `LPM_STAT_OFF, 0); `CHK("status", 32'h00000001, rd)
    `CHK("hresp", 1'b0, hresp)
    bus(1, `LPM_CTRL_OFF, 32'h00004200);
    bus(0, `LPM_CTRL_OFF, 0); `CHK("ctrl", 32'h00004200, rd)
    bus(1, 32'h00000010, 32'hffffffff);
    bus(0, 32'h00000010, 0); `CHK("unmapped", 32'h00000000, rd)
    bus(1, `LPM_SUPPLY_OFF, 32'h000000f1);
    repeat (2) @(posedge clock);
    `CHK("detector", 5'h1f, {detector_enable, detector_src_pin, detector_level})
  endtask
  task automatic t_bor;
    opt_brownout_rise <= 3'h5;
    opt_brownout_fall <= 3'h2;
    repeat (2) @(posedge clock);
    `CHK("bor", 7'h6a, {brownout_reset_en, brownout_rise_sel, brownout_fall_sel})
  endtask
  task automatic t_sleep;
    go(1); `CHK("sleep wfi", 4'ha, {sleep_active, cpu_clock_en, main_regulator_on, 1'b0})
    wake(0); `CHK("irq wake", 1'b1, cpu_clock_en)
    go(2); `CHK("sleep wfe", 1'b1, sleep_active)
    wake(1); `CHK("event wake", 1'b1, cpu_clock_en)
    pending_as_event <= 1'b1;
    go(2);
    periph_pending <= 1'b1;
    @(posedge clock) periph_pending <= 1'b0;
    repeat (2) @(posedge clock);
    `CHK("pending wake", 1'b1, cpu_clock_en)
    pending_as_event <= 1'b0;
    sleep_after_handler <= 1'b1;
    go(3); `CHK("sleep exit", 1'b1, sleep_active)
    wake(0); `CHK("exit wake", 1'b1, cpu_clock_en)
    sleep_after_handler <= 1'b0;
  endtask
  task automatic t_stop;
    bus(1, `LPM_CTRL_OFF, 32'h00004200);
    deep_sleep_select <= 1'b1;
    go(1); `CHK("stop lpr", 5'h1a, {stop_active, low_power_regulator_on,
      main_regulator_on, core_volt_low, periph_clock_en})
    wake(2); `CHK("stop exit", 3'h6, {cpu_clock_en, main_regulator_on, core_volt_low})
    bus(0, `LPM_CTRL_OFF, 0); `CHK("ctrl", 32'h00004000, rd)
    go(2); `CHK("stop 1v2", 3'h6, {stop_active, low_power_regulator_on, core_volt_low})
    wake(3);
    bus(1, `LPM_CTRL_OFF, 32'h00000000);
    go(1); `CHK("stop mr", 3'h5, {stop_active, low_power_regulator_on, main_regulator_on})
    line_wake_irq <= 1'b1;
    @(posedge clock) line_wake_irq <= 1'b0;
    repeat (2) @(posedge clock);
    `CHK("line wake", 1'b1, cpu_clock_en)
    for (int i = 0; i < 4; i++) begin
      {sysclk_is_slow, alarm_pending, periph_pending, line_pending} <= 4'h1 << i;
      go(1); `CHK("refused", 2'h1, {stop_active, cpu_clock_en})
    end
    {sysclk_is_slow, alarm_pending, periph_pending, line_pending} <= 4'h0;
    bus(1, `LPM_CTRL_OFF, 32'h0000c000);
    go(1);
    slow_osc_fail <= 1'b1;
    @(posedge clock) slow_osc_fail <= 1'b0;
    @(posedge clock);
    `CHK("nmi", 2'h3, {nmi_request, cpu_clock_en})
    deep_sleep_select <= 1'b0;
  endtask
  task automatic t_det;
    supply_above_raw <= 1'b1;
    repeat (6) @(posedge clock);
    `CHK("event high", 1'b1, event_line16)
    supply_above_raw <= 1'b0;
    repeat (6) @(posedge clock);
    `CHK("event low", 1'b0, event_line16)
  endtask
  task end_of_test;
    if (failures == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    {clock, reset_n, hsel, hwrite, supply_above_raw, deep_sleep_select} = 6'h0;
    {sleep_after_handler, pending_as_event, periph_pending, line_pending} = 4'h0;
    {alarm_pending, line_wake_irq, slow_osc_fail, sysclk_is_slow} = 4'h0;
    {clock_enable, opt_brownout_en, opt_brownout_rise, opt_brownout_fall} = 8'hc0;
    {haddr, hwdata, htrans, req, wk, hsize} = {64'h0, 4'h0, 4'h0, 3'h2};
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    t_regs;
    t_bor;
    t_sleep;
    t_stop;
    t_det;
    end_of_test;
  end
endmodule
`default_nettype wire
